// file: hw/ccsu_pkg.sv
`default_nettype none
package ccsu_pkg;

    // ==========================================================
    // event flag and status byte layout
    localparam int          PON_BIT       = 7;
    localparam int          CME_BIT       = 5;
    localparam int          EXE_BIT       = 4;
    localparam int          DDE_BIT       = 3;
    localparam int          QUE_BIT       = 2;
    localparam int          OPC_BIT       = 0;
    localparam int          ESB_BIT       = 5;
    localparam int          MSS_BIT       = 6;
    localparam logic [7:0]  SUMMARY_BITS  = 8'h60;

    // ==========================================================
    // values after reset
    localparam logic [7:0]  EVENT_MASK_RESET   = 8'h00;
    localparam logic [7:0]  SERVICE_MASK_RESET = 8'h00;
    localparam logic [7:0]  FLAGS_RESET        = 8'h80;

    // ==========================================================
    // characters
    localparam logic [7:0]  ASTERISK   = 8'h2a;
    localparam logic [7:0]  ASCII_ZERO = 8'h30;
    localparam logic [7:0]  ASCII_ONE  = 8'h31;

    // ==========================================================
    // identification reply; every field value is arbitrary
    localparam int          IDN_LEN  = 43;
    localparam logic [5:0]  IDN_END  = 6'h2b;
    localparam logic [8*IDN_LEN-1:0] IDN_TEXT =
        "MAKER,MODEL-100-1.0 01-01-2000,SN00000,V1.0";

    // ==========================================================
    // commands delivered by the message parser
    typedef enum logic [3:0] {
        CMD_CLS,
        CMD_ESE,
        CMD_ESE_Q,
        CMD_ESR_Q,
        CMD_IDN_Q,
        CMD_OPC,
        CMD_OPC_Q,
        CMD_SRE,
        CMD_SRE_Q,
        CMD_STB_Q,
        CMD_OTHER
    } command_e;

    typedef struct packed {
        logic [7:0] lead;
        command_e   code;
        logic [7:0] arg;
    } command_s;

    typedef struct packed {
        logic power_on;
        logic command_error;
        logic execution_error;
        logic device_error;
        logic query_error;
    } event_s;

    typedef struct packed {
        logic [1:0] count;
        logic [7:0] d0;
        logic [7:0] d1;
        logic [7:0] d2;
    } number_s;

endpackage : ccsu_pkg
`default_nettype wire

// file: hw/common_command_status_unit.sv
// Summary of operation
// - only asterisk-led commands are taken
// - clear flags and status, keep enable masks
// - clear status also empties error queue
// - event mask holds 0..255, resets zero
// - summary bit 5 from flags AND mask
// - fixed eight-bit event flag layout
// - mask query returns mask unchanged
// - flag query returns flags then clears
// - parser and device errors raise flags
// - completion flag waits for idle device
// - pending completion does not block commands
// - completion query replies ASCII one
// - completion query blocks later commands
// - identification reply is fixed text fields
// - service mask bit 6 cannot be set
// - status byte bit 6 is master summary
`default_nettype none
module common_command_status_unit
    import ccsu_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // parsed commands
    input  wire logic       cmd_valid_in,
    input  wire command_s   cmd_in,
    output var  logic       cmd_ready_out,
    // events and device state
    input  wire event_s     events_in,
    input  wire logic       busy_in,
    input  wire logic [7:0] status_bits_in,
    // reply byte stream
    output var  logic       reply_valid_out,
    output var  logic [7:0] reply_data_out,
    input  wire logic       reply_ready_in,
    // status outputs
    output var  logic [7:0] status_byte_out,
    output var  logic [7:0] event_flags_out,
    output var  logic       clear_status_out,
    output var  logic       error_queue_clear_out
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_NUMBER,
        ST_IDENT,
        ST_OPC_WAIT
    } state_e;

    // ==========================================================
    // helpers
    function automatic number_s to_decimal(input logic [7:0] v);
        number_s    n;
        logic [7:0] h;
        logic [7:0] t;
        logic [7:0] o;
        h = v / 8'h64;
        t = (v / 8'h0a) % 8'h0a;
        o = v % 8'h0a;
        n.count = (v >= 8'h64) ? 2'h3 : ((v >= 8'h0a) ? 2'h2 : 2'h1);
        if (v >= 8'h64)
        begin
            n.d0 = ASCII_ZERO + h;
            n.d1 = ASCII_ZERO + t;
            n.d2 = ASCII_ZERO + o;
        end
        else if (v >= 8'h0a)
        begin
            n.d0 = ASCII_ZERO + t;
            n.d1 = ASCII_ZERO + o;
            n.d2 = ASCII_ZERO;
        end
        else
        begin
            n.d0 = ASCII_ZERO + o;
            n.d1 = ASCII_ZERO;
            n.d2 = ASCII_ZERO;
        end
        return n;
    endfunction : to_decimal

    function automatic logic [7:0] idn_char(input logic [5:0] i);
        return IDN_TEXT[8*(IDN_LEN-1-int'(i)) +: 8];
    endfunction : idn_char

    // ==========================================================
    // registers
    state_e     state;
    state_e     next_state;
    logic [7:0] flags;
    logic [7:0] event_mask;
    logic [7:0] service_mask;
    logic       opc_armed;
    number_s    num_buf;
    logic [5:0] idx;

    // ==========================================================
    // command decode
    wire        accept  = cmd_valid_in && cmd_ready_out
                          && (cmd_in.lead == ASTERISK);
    wire        do_cls  = accept && (cmd_in.code == CMD_CLS);
    wire        do_ese  = accept && (cmd_in.code == CMD_ESE);
    wire        do_eseq = accept && (cmd_in.code == CMD_ESE_Q);
    wire        do_esrq = accept && (cmd_in.code == CMD_ESR_Q);
    wire        do_idnq = accept && (cmd_in.code == CMD_IDN_Q);
    wire        do_opc  = accept && (cmd_in.code == CMD_OPC);
    wire        do_opcq = accept && (cmd_in.code == CMD_OPC_Q);
    wire        do_sre  = accept && (cmd_in.code == CMD_SRE);
    wire        do_sreq = accept && (cmd_in.code == CMD_SRE_Q);
    wire        do_stbq = accept && (cmd_in.code == CMD_STB_Q);
    wire        start_num = do_eseq || do_esrq || do_sreq || do_stbq;

    wire [7:0]  num_value = do_eseq ? event_mask :
                            do_esrq ? flags :
                            do_sreq ? service_mask :
                            status_byte_out;
    wire number_s num_src = to_decimal(num_value);

    wire        reply_taken = reply_valid_out && reply_ready_in;

    // ==========================================================
    // event flags; a new event beats a clear in the same cycle
    wire        opc_done = opc_armed && !busy_in;
    wire [7:0]  event_bits;
    assign event_bits[PON_BIT] = events_in.power_on;
    assign event_bits[6]       = 1'b0;
    assign event_bits[CME_BIT] = events_in.command_error;
    assign event_bits[EXE_BIT] = events_in.execution_error;
    assign event_bits[DDE_BIT] = events_in.device_error;
    assign event_bits[QUE_BIT] = events_in.query_error;
    assign event_bits[1]       = 1'b0;
    assign event_bits[OPC_BIT] = opc_done;

    wire        flags_clear = do_cls || do_esrq;
    wire [7:0]  next_flags  = (flags_clear ? 8'h00 : flags) | event_bits;

    // ==========================================================
    // status byte, rebuilt every cycle from current registers and status_bits_in
    wire        event_summary_flag = |(flags & event_mask);
    wire [7:0]  stb_low = (status_bits_in & ~SUMMARY_BITS)
                          | ({7'h00, event_summary_flag} << ESB_BIT);
    wire        master_summary_flag = |(stb_low & service_mask);
    // cleared status zeroes the external summaries too, so no stale bits
    wire [7:0]  next_status_byte = do_cls ? 8'h00
                          : (stb_low | ({7'h00, master_summary_flag} << MSS_BIT));

    // ==========================================================
    // sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
            begin
                if (start_num)
                    next_state = ST_NUMBER;
                else if (do_idnq)
                    next_state = ST_IDENT;
                else if (do_opcq)
                    next_state = ST_OPC_WAIT;
            end
            ST_NUMBER:
                if (reply_taken && (idx == {4'h0, num_buf.count}))
                    next_state = ST_IDLE;
            ST_IDENT:
                if (reply_taken && (idx == IDN_END))
                    next_state = ST_IDLE;
            ST_OPC_WAIT:
                if (reply_taken)
                    next_state = ST_IDLE;
            default:
                next_state = ST_IDLE;
        endcase
    end

    // ==========================================================
    // register file
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            flags           <= FLAGS_RESET;
            event_mask      <= EVENT_MASK_RESET;
            service_mask    <= SERVICE_MASK_RESET;
            opc_armed       <= 1'b0;
            status_byte_out <= 8'h00;
            event_flags_out <= FLAGS_RESET;
        end
        else
        begin
            flags           <= next_flags;
            event_flags_out <= next_flags;
            status_byte_out <= next_status_byte;
            if (do_ese)
                event_mask <= cmd_in.arg;
            if (do_sre)
                service_mask <= cmd_in.arg & ~(8'h01 << MSS_BIT);
            // arming does not stall the command port
            if (do_cls || opc_done)
                opc_armed <= 1'b0;
            else if (do_opc)
                opc_armed <= 1'b1;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            clear_status_out      <= 1'b0;
            error_queue_clear_out <= 1'b0;
        end
        else
        begin
            clear_status_out      <= do_cls;
            error_queue_clear_out <= do_cls;
        end
    end

    // ==========================================================
    // reply stream; commands wait while a reply is out
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state           <= ST_IDLE;
            cmd_ready_out   <= 1'b0;
            reply_valid_out <= 1'b0;
            reply_data_out  <= 8'h00;
            idx             <= 6'h00;
            num_buf         <= '0;
        end
        else
        begin
            state         <= next_state;
            cmd_ready_out <= (next_state == ST_IDLE);
            case (state)
                ST_IDLE:
                begin
                    idx <= 6'h01;
                    if (start_num)
                    begin
                        num_buf         <= num_src;
                        reply_valid_out <= 1'b1;
                        reply_data_out  <= num_src.d0;
                    end
                    else if (do_idnq)
                    begin
                        reply_valid_out <= 1'b1;
                        reply_data_out  <= idn_char(6'h00);
                    end
                end
                ST_NUMBER:
                    if (reply_taken)
                    begin
                        if (idx == {4'h0, num_buf.count})
                            reply_valid_out <= 1'b0;
                        else
                        begin
                            reply_data_out <= (idx == 6'h01) ?
                                              num_buf.d1 : num_buf.d2;
                            idx            <= idx + 6'h01;
                        end
                    end
                ST_IDENT:
                    if (reply_taken)
                    begin
                        if (idx == IDN_END)
                            reply_valid_out <= 1'b0;
                        else
                        begin
                            reply_data_out <= idn_char(idx);
                            idx            <= idx + 6'h01;
                        end
                    end
                ST_OPC_WAIT:
                    if (reply_taken)
                        reply_valid_out <= 1'b0;
                    else if (!reply_valid_out && !busy_in)
                    begin
                        reply_valid_out <= 1'b1;
                        reply_data_out  <= ASCII_ONE;
                    end
                default:
                    reply_valid_out <= 1'b0;
            endcase
        end
    end

endmodule : common_command_status_unit
`default_nettype wire

// file: verif/ccsu_assertions.sv
`default_nettype none
module ccsu_assertions
    import ccsu_pkg::*;
(
    // clock and reset
    input wire logic       clk_in,
    input wire logic       reset_in,
    // command side
    input wire logic       cmd_valid_in,
    input wire command_s   cmd_in,
    input wire logic       cmd_ready_out,
    input wire event_s     events_in,
    input wire logic       busy_in,
    // reply and status side
    input wire logic       reply_valid_out,
    input wire logic [7:0] reply_data_out,
    input wire logic       reply_ready_in,
    input wire logic [7:0] status_byte_out,
    input wire logic [7:0] event_flags_out,
    input wire logic       clear_status_out,
    input wire logic       error_queue_clear_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    // ==========
    // accepted asterisk-led command
    wire logic take = cmd_valid_in && cmd_ready_out && cmd_in.lead == ASTERISK;
    property p_reset;
        $fell(reset_in) |-> event_flags_out == FLAGS_RESET && !cmd_ready_out;
    endproperty
    a_reset: assert property (p_reset)
        else $error("bad state after reset");
    property p_unused;
        event_flags_out[6] == 1'b0 && event_flags_out[1] == 1'b0;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused flag bit set");
    property p_cls;
        take && cmd_in.code == CMD_CLS |=> clear_status_out
            && error_queue_clear_out && status_byte_out == 8'h00;
    endproperty
    a_cls: assert property (p_cls)
        else $error("clear status not carried out");
    property p_lead;
        cmd_valid_in && cmd_ready_out && cmd_in.lead != ASTERISK
            |=> !clear_status_out && !reply_valid_out;
    endproperty
    a_lead: assert property (p_lead)
        else $error("command without asterisk acted on");
    property p_err;
        events_in.command_error |=> event_flags_out[CME_BIT];
    endproperty
    a_err: assert property (p_err)
        else $error("command error flag not raised");
    property p_esr;
        take && cmd_in.code == CMD_ESR_Q && events_in == '0
            |=> (event_flags_out & 8'hfe) == 8'h00 && reply_valid_out;
    endproperty
    a_esr: assert property (p_esr)
        else $error("flags not cleared by read");
    property p_block;
        take && (cmd_in.code == CMD_OPC_Q || cmd_in.code == CMD_IDN_Q)
            |=> !cmd_ready_out;
    endproperty
    a_block: assert property (p_block)
        else $error("commands not held off");
    property p_wait;
        busy_in && !cmd_ready_out && !reply_valid_out |=> !reply_valid_out;
    endproperty
    a_wait: assert property (p_wait)
        else $error("completion reply while busy");
    property p_hold;
        reply_valid_out && !reply_ready_in
            |=> reply_valid_out && $stable(reply_data_out);
    endproperty
    a_hold: assert property (p_hold)
        else $error("reply byte dropped");
    c_cls: cover property (take && cmd_in.code == CMD_CLS);
    c_opcq: cover property (take && cmd_in.code == CMD_OPC_Q ##1 busy_in);
    c_stall: cover property (reply_valid_out && !reply_ready_in);
endmodule : ccsu_assertions
bind common_command_status_unit ccsu_assertions u_chk (.clk_in, .reset_in,
    .cmd_valid_in, .cmd_in, .cmd_ready_out, .events_in, .busy_in,
    .reply_valid_out, .reply_data_out, .reply_ready_in, .status_byte_out,
    .event_flags_out, .clear_status_out, .error_queue_clear_out);
`default_nettype wire

// file: verif/reply_sink.sv
`default_nettype none
module reply_sink
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // pacing and handshake
    input  wire logic slow_in,
    output var  logic ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // slow mode takes every other cycle, so replies must stand
    always_ff @(posedge clk_in)
        ready_out <= !reset_in && (!slow_in || !ready_out);
endmodule : reply_sink
`default_nettype wire

// file: verif/test_common_command_status_unit.sv
`default_nettype none
module test_common_command_status_unit
    import ccsu_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clk_in = 1'b0;
    logic                 reset_in = 1'b1;
    logic                 cmd_valid_in = 1'b0;
    command_s             cmd_in = '0;
    event_s               events_in = '0;
    logic                 busy_in = 1'b0;
    logic [7:0]           status_bits_in = 8'h00;
    logic                 slow = 1'b0;
    logic                 reply_ready_in, cmd_ready_out, reply_valid_out;
    logic                 clear_status_out, error_queue_clear_out;
    logic [7:0]           reply_data_out, status_byte_out, event_flags_out;
    logic [8*IDN_LEN-1:0] text;
    logic [15:0]          num;
    int                   cnt, cycles, err_total, num_checks;
    logic [7:0]           val [3] = '{8'h00, 8'hff, 8'h3c};
    logic [7:0]           ebit [5] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04};
    common_command_status_unit DUT (.clk_in, .reset_in, .cmd_valid_in,
        .cmd_in, .cmd_ready_out, .events_in, .busy_in, .status_bits_in,
        .reply_valid_out, .reply_data_out, .reply_ready_in,
        .status_byte_out, .event_flags_out, .clear_status_out,
        .error_queue_clear_out);
    reply_sink sink (.clk_in, .reset_in, .slow_in(slow),
        .ready_out(reply_ready_in));
    initial
        forever #4 clk_in = ~clk_in;
    // ==========
    // access tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic send(input command_e c, input logic [7:0] a,
                        input logic [7:0] ld = ASTERISK);
        @(posedge clk_in);
        cmd_valid_in <= 1'b1;
        cmd_in <= '{ld, c, a};
        do @(posedge clk_in); while (cmd_ready_out !== 1'b1);
        cmd_valid_in <= 1'b0;
    endtask : send
    // digits arrive most significant first, no terminator
    task automatic receive();
        cnt = 0;
        num = '0;
        do
        begin
            @(posedge clk_in);
            if (reply_valid_out === 1'b1 && reply_ready_in === 1'b1)
            begin
                text = {text[8*IDN_LEN-9:0], reply_data_out};
                num = num * 16'd10 + 16'(reply_data_out - ASCII_ZERO);
                cnt++;
            end
        end
        while (cnt == 0 || reply_valid_out === 1'b1);
    endtask : receive
    task automatic query(input command_e c, input logic [15:0] exp);
        send(c, 8'h00);
        receive();
        check(num, exp);
    endtask : query
    task automatic pulse(input event_s e);
        @(posedge clk_in);
        events_in <= e;
        @(posedge clk_in);
        events_in <= '0;
    endtask : pulse
    task automatic settle();
        repeat (3) @(posedge clk_in);
        #1;
    endtask : settle
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : final_report
    // far beyond the few hundred cycles the sequence needs
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            final_report();
        end
    end
    // ==========
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk_in);
        reset_in <= 1'b0;
        @(posedge clk_in);
        #1;
        check({event_flags_out, status_byte_out}, 16'h8000);
        query(CMD_ESE_Q, 16'd0);
        query(CMD_ESR_Q, 16'd128);
        query(CMD_ESR_Q, 16'd0);
        for (int i = 0; i < 3; i++)
        begin
            send(CMD_ESE, val[i]);
            query(CMD_ESE_Q, 16'(val[i]));
        end
        for (int i = 0; i < 5; i++)
        begin
            pulse(event_s'(5'h10 >> i));
            query(CMD_ESR_Q, 16'(ebit[i]));
        end
        pulse(event_s'(5'h08));
        settle();
        check(status_byte_out, 8'h20);
        send(CMD_SRE, 8'h60);
        query(CMD_SRE_Q, 16'd32);
        query(CMD_STB_Q, 16'd96);
        // outside summary bit; bits 5 and 6 of the input are overridden
        status_bits_in <= 8'h48;
        settle();
        query(CMD_STB_Q, 16'd104);
        send(CMD_CLS, 8'h00);
        #1;
        check({clear_status_out, error_queue_clear_out, status_byte_out,
               event_flags_out}, {2'b11, 16'h0000});
        @(posedge clk_in);
        status_bits_in <= 8'h00;
        query(CMD_ESE_Q, 16'd60);
        send(CMD_ESE, 8'h00);
        pulse(event_s'(5'h08));
        settle();
        check(status_byte_out, 8'h00);
        send(CMD_ESE, 8'h3c);
        settle();
        check(status_byte_out, 8'h60);
        send(CMD_CLS, 8'h00, 8'h21);
        #1;
        check({clear_status_out, event_flags_out}, 9'h020);
        query(CMD_ESR_Q, 16'd32);
        settle();
        query(CMD_STB_Q, 16'd0);
        busy_in <= 1'b1;
        send(CMD_OPC, 8'h00);
        query(CMD_ESR_Q, 16'd0);
        busy_in <= 1'b0;
        settle();
        query(CMD_ESR_Q, 16'd1);
        busy_in <= 1'b1;
        send(CMD_OPC_Q, 8'h00);
        settle();
        check({cmd_ready_out, reply_valid_out}, 2'b00);
        @(posedge clk_in);
        busy_in <= 1'b0;
        receive();
        check({cnt, num}, {32'd1, 16'd1});
        slow <= 1'b1;
        send(CMD_IDN_Q, 8'h00);
        receive();
        check({cnt == IDN_LEN, text === IDN_TEXT}, 2'b11);
        final_report();
    end
endmodule : test_common_command_status_unit
`default_nettype wire
